// ===== tb/bmpc_asserts.sv
// Port-level checker of the bus mode and pull control block.
`timescale 1ns/100ps
`default_nettype none
module bmpc_asserts
(
	input wire logic       clk_in,
	input wire logic       nrst_in,
	input wire logic [2:0] strap_mode_in,
	input wire logic [3:0] addr_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic       int_access_in,
	input wire logic [7:0] port_k_dir_in,
	input wire logic [7:0] rdata_out,
	input wire logic       echo_ext_out,
	input wire logic [2:0] operating_mode_field_out,
	input wire logic       internal_visibility_out,
	input wire logic       visible_cycle_out,
	input wire logic       port_k_mapped_out,
	input wire logic       port_e_mapped_out,
	input wire logic [7:0] pull_k_out,
	input wire logic [7:0] pull_e_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////
	a_mode_delay: assert property (wr_in && addr_in == 4'hB && !$past(wr_in, 2) |=>
		$stable(operating_mode_field_out)) else $error("mode changed in the cycle after its write");
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("read data without a read");
	a_echo_cause: assert property (echo_ext_out |-> $past((rd_in || wr_in) &&
		(addr_in == 4'hB || addr_in == 4'hC))) else $error("echo without an access");
	// The level check waits for a settled visibility bit, so a write landing does not count.
	a_vis_cycle: assert property ($past(int_access_in) && $stable(internal_visibility_out) && $past(nrst_in, 2)
		|-> visible_cycle_out == internal_visibility_out) else $error("visible cycle wrong");
	a_mode_reset: assert property ($rose(nrst_in) |-> ##3 operating_mode_field_out == strap_mode_in)
		else $error("mode not loaded from strap");
	a_single_map: assert property (operating_mode_field_out[1:0] == 2'b00 && $stable(operating_mode_field_out)
		|-> port_k_mapped_out && port_e_mapped_out) else $error("single chip port unmapped");
	a_periph_unmap: assert property (operating_mode_field_out == 3'h6 && $stable(operating_mode_field_out)
		|-> !port_k_mapped_out) else $error("port k mapped in peripheral mode");
	a_pull_input: assert property ($stable(port_k_dir_in) |-> (pull_k_out & port_k_dir_in) == 8'h00)
		else $error("pull on an output pin");
	a_pull_e_gap: assert property (pull_e_out[6:5] == 2'b00) else $error("pull on port e bits 6 or 5");
endmodule // bmpc_asserts
bind bus_mode_and_pull_control bmpc_asserts u_chk (.clk_in, .nrst_in, .strap_mode_in, .addr_in, .wr_in, .rd_in,
	.int_access_in, .port_k_dir_in, .rdata_out, .echo_ext_out, .operating_mode_field_out, .internal_visibility_out,
	.visible_cycle_out, .port_k_mapped_out, .port_e_mapped_out, .pull_k_out, .pull_e_out);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the bus mode and pull control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       clk_in, nrst_in, secure_in, wr_in, rd_in, int_access_in, echo_seen;
	logic [2:0] strap_mode_in;
	logic [3:0] addr_in;
	logic [7:0] wdata_in, pe [5];
	wire logic [7:0] rdata_out, pull_k_out, pull_e_out, pull_b_out, pull_a_out;
	wire logic [2:0] operating_mode_field_out;
	wire logic       echo_ext_out, internal_visibility_out, visible_cycle_out, port_k_mapped_out, port_e_mapped_out;
	int         num_errors = 0, num_checks = 0, cyc = 0;
	// Directions stay fixed so the expected pull patterns are plain constants.
	bus_mode_and_pull_control DUT (.clk_in, .nrst_in, .strap_mode_in, .secure_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .int_access_in, .port_k_dir_in(8'h0F), .port_e_dir_in(8'h21), .port_b_dir_in(8'h80),
		.port_a_dir_in(8'h3C), .rdata_out, .echo_ext_out, .operating_mode_field_out, .internal_visibility_out,
		.visible_cycle_out, .port_k_mapped_out, .port_e_mapped_out, .pull_k_out, .pull_e_out, .pull_b_out,
		.pull_a_out);
	////////////////////////////////////////////////////////////////
	task results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rst(input logic [2:0] m);
		@(posedge clk_in);
		nrst_in <= 1'b0;
		strap_mode_in <= m;
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		echo_seen = echo_ext_out;
		chk(rdata_out, e);
	endtask
	// The read lands two edges after the write, just when the mode output has moved.
	task wm(input logic [7:0] d, input logic [7:0] e, input logic [2:0] m);
		wr(4'hB, d);
		rd(4'hB, e);
		chk({5'h0, operating_mode_field_out}, {5'h0, m});
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		int_access_in <= ~int_access_in;
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			results();
		end
	end
	initial
	begin
		logic em, vs, mp;
		{nrst_in, secure_in, wr_in, rd_in, int_access_in, strap_mode_in, addr_in, wdata_in} = '0;
		pe = '{8'h80, 8'h10, 8'h02, 8'h01, 8'hFF};
		for (logic [3:0] m = 0; m < 8; m++)
		begin
			em = (m == 1 || m == 3);
			vs = em || m == 2;
			mp = (m == 0 || m == 2 || m == 4);
			rst(m[2:0]);
			chk({5'h0, operating_mode_field_out}, {5'h0, m[2:0]});
			chk({6'h0, port_k_mapped_out, port_e_mapped_out}, {6'h0, m != 6 && !em, !em});
			rd(4'hB, mp ? {m[2:0], 1'b0, vs, 1'b0, em, em} : 8'h00);
			chk({7'h0, echo_seen}, {7'h0, !mp});
			rd(4'hC, 8'h00);
		end
		rst(3'h0);
		rd(4'hF, 8'h00);
		@(posedge clk_in) secure_in <= 1'b1;
		wm(8'h40, 8'h00, 3'h0);
		@(posedge clk_in) secure_in <= 1'b0;
		wm(8'hC0, 8'h00, 3'h0);
		wm(8'h5F, 8'h4B, 3'h2);
		wm(8'h03, 8'h03, 3'h0);
		chk({6'h0, port_k_mapped_out, port_e_mapped_out}, 8'h03);
		wm(8'h80, 8'h80, 3'h4);
		wm(8'hA9, 8'h00, 3'h5);
		chk({6'h0, internal_visibility_out, port_e_mapped_out}, 8'h03);
		wm(8'hE0, 8'h00, 3'h5);
		rst(3'h4);
		wm(8'h08, 8'h88, 3'h4);
		wm(8'h89, 8'h88, 3'h4);
		wm(8'h80, 8'h88, 3'h4);
		rst(3'h1);
		wm(8'h00, 8'h00, 3'h1);
		chk({5'h0, internal_visibility_out, port_k_mapped_out, port_e_mapped_out}, 8'h04);
		rst(3'h0);
		foreach (pe[i])
		begin
			wr(4'hC, pe[i]);
			rd(4'hC, pe[i] & 8'h93);
			chk(pull_k_out, pe[i][7] ? 8'hF0 : 8'h00);
			chk(pull_e_out, pe[i][4] ? 8'h9E : 8'h00);
			chk(pull_b_out, pe[i][1] ? 8'h7F : 8'h00);
			chk(pull_a_out, pe[i][0] ? 8'hC3 : 8'h00);
		end
		results();
	end
endmodule // tb
`default_nettype wire

// ===== verilog/bus_mode_and_pull_control.v
// Operating mode register, pull enable register and map decisions of the external bus interface.
// Notes on behaviour
// - Three-bit field reports current operating mode.
// - Reset loads mode-dependent values from strapped mode.
// - Mode register writes take effect one cycle later.
// - Expanded and peripheral modes pass accesses externally.
// - Mode register readable whenever mapped.
// - Low mode bit set: mode field frozen.
// - Special modes: free writes, never touching 110.
// - Normal single chip: one write to expanded.
// - Visibility bit shows internal cycles externally.
// - Visibility, port K emulation: once, never, anytime.
// - Port K emulation unmaps port K in expanded.
// - Port E emulation writable only in special.
// - Port E emulation unmaps port E registers in expanded and peripheral.
// - Pull enable register at 0x000C, read/write.
// - Pulls act only on input pins.
// - Secured part rejects mode field writes.
// - Special to normal single keeps one write.
// - Pull bits: K=7, E=4, B=1, A=0.
`timescale 1ns/100ps
`default_nettype none
`include "bus_mode_defs.vh"
module bus_mode_and_pull_control
(
	input  wire       clk_in,
	input  wire       nrst_in,
	input  wire [2:0] strap_mode_in,
	input  wire       secure_in,
	input  wire [3:0] addr_in,
	input  wire [7:0] wdata_in,
	input  wire       wr_in,
	input  wire       rd_in,
	input  wire       int_access_in,
	input  wire [7:0] port_k_dir_in,
	input  wire [7:0] port_e_dir_in,
	input  wire [7:0] port_b_dir_in,
	input  wire [7:0] port_a_dir_in,
	output reg  [7:0] rdata_out,
	output reg        echo_ext_out,
	output reg  [2:0] operating_mode_field_out,
	output reg        internal_visibility_out,
	output reg        visible_cycle_out,
	output reg        port_k_mapped_out,
	output reg        port_e_mapped_out,
	output wire [7:0] pull_k_out,
	output wire [7:0] pull_e_out,
	output wire [7:0] pull_b_out,
	output wire [7:0] pull_a_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers and decoded mode classes.
	reg  [2:0] mode;
	reg        vis;
	reg        emulate_port_k;
	reg        emulate_port_e;
	reg  [7:0] pull;
	reg        mode_once_left;
	reg        vis_once_left;
	reg        emk_once_left;
	reg        pend;
	reg  [7:0] pend_data;
	reg        strap_load;
	reg  [7:0] next_rdata;
	reg  [2:0] next_mode;
	reg        next_vis;
	reg        next_emk;
	reg        next_eme;
	reg        next_mode_once;
	reg        next_vis_once;
	reg        next_emk_once;
	wire [2:0] req_mode;
	wire       is_special;
	wire       is_emul;
	wire       is_normal;
	wire       is_single;
	wire       is_expanded;
	wire       regs_mapped;
	wire       hit_mode;
	wire       hit_pull;
	wire       hit_stat;
	wire       own_addr;
	wire       next_echo;
	wire       next_k_map;
	wire       next_e_map;
	wire       strap_emul;
	wire       strap_test;

	// Strap decode for the reset values of the three configuration bits.
	assign strap_emul  = (strap_mode_in == `M_EMUL_NARROW) || (strap_mode_in == `M_EMUL_WIDE);
	assign strap_test  = (strap_mode_in == `M_SPECIAL_TEST);
	assign req_mode    = pend_data[`MODE_HI:`MODE_LO];
	assign is_special  = (mode == `M_SPECIAL_SINGLE) || (mode == `M_SPECIAL_TEST) || (mode == `M_PERIPHERAL);
	assign is_emul     = (mode == `M_EMUL_NARROW) || (mode == `M_EMUL_WIDE);
	assign is_normal   = !is_special && !is_emul;
	assign is_single   = (mode == `M_SPECIAL_SINGLE) || (mode == `M_NORMAL_SINGLE);
	assign is_expanded = mode[0];
	// Special test is treated as a single-chip-like mode with its registers mapped.
	assign regs_mapped = !is_expanded && (mode != `M_PERIPHERAL);
	assign hit_mode    = regs_mapped && (addr_in == `ADDR_BUS_CONFIG_SELECT);
	assign hit_pull    = regs_mapped && (addr_in == `ADDR_PULL_RESISTOR_EN);
	// The status index answers in every mode; the external bus never mirrors it.
	assign hit_stat    = (addr_in == `ADDR_STATUS);

	////////////////////////////////////////////////////////////////////////////////
	// Write permission: the write is captured first and judged one cycle later,
	// so a change never acts in the very cycle of the write.
	always @*
	begin
		next_mode      = mode;
		next_mode_once = mode_once_left;
		if (pend && !mode[0] && !secure_in)
		begin
			if (!mode[2])
			begin
				if ((mode != `M_PERIPHERAL) && (req_mode != `M_PERIPHERAL))
				begin
					next_mode = req_mode;
					// Leaving for normal single chip keeps one write, else none.
					next_mode_once = (req_mode == `M_NORMAL_SINGLE);
				end
			end
			else if ((mode == `M_NORMAL_SINGLE) && mode_once_left)
			begin
				if ((req_mode == `M_NORMAL_NARROW) || (req_mode == `M_NORMAL_WIDE))
					next_mode = req_mode;
				// Any attempt spends the single write, accepted or not.
				next_mode_once = 1'b0;
			end
		end
	end

	// Visibility and port K emulation share one permission pattern but keep separate once-flags.
	always @*
	begin
		next_vis      = vis;
		next_emk      = emulate_port_k;
		next_vis_once = vis_once_left;
		next_emk_once = emk_once_left;
		if (pend && is_special)
		begin
			next_vis = pend_data[`BIT_VIS];
			next_emk = pend_data[`BIT_EMK];
		end
		else if (pend && is_normal)
		begin
			if (vis_once_left)
			begin
				next_vis      = pend_data[`BIT_VIS];
				next_vis_once = 1'b0;
			end
			if (emk_once_left)
			begin
				next_emk      = pend_data[`BIT_EMK];
				next_emk_once = 1'b0;
			end
		end
	end

	// Port E emulation is a special-mode privilege only.
	always @*
	begin
		next_eme = emulate_port_e;
		if (pend && is_special)
			next_eme = pend_data[`BIT_EME];
	end

	////////////////////////////////////////////////////////////////////////////////
	// State. The strap is taken by a clocked load on the first edge after release.
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			strap_load     <= 1'b1;
			mode           <= `M_SPECIAL_SINGLE;
			vis            <= 1'b0;
			emulate_port_k            <= 1'b0;
			emulate_port_e            <= 1'b0;
			mode_once_left <= 1'b1;
			vis_once_left  <= 1'b1;
			emk_once_left  <= 1'b1;
		end
		else if (strap_load)
		begin
			strap_load     <= 1'b0;
			mode           <= strap_mode_in;
			vis            <= strap_emul || strap_test;
			emulate_port_k            <= strap_emul;
			emulate_port_e            <= strap_emul;
		end
		else
		begin
			mode           <= next_mode;
			vis            <= next_vis;
			emulate_port_k            <= next_emk;
			emulate_port_e            <= next_eme;
			mode_once_left <= next_mode_once;
			vis_once_left  <= next_vis_once;
			emk_once_left  <= next_emk_once;
		end
	end

	// The pending write is captured even when the decision later refuses it.
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			pend      <= 1'b0;
			pend_data <= 8'h00;
		end
		else
		begin
			pend <= wr_in && hit_mode && !strap_load;
			if (wr_in && hit_mode && !strap_load)
				pend_data <= wdata_in;
		end
	end

	// Only the four port enable bits are kept; the rest read back as zero.
	always @(posedge clk_in)
	begin
		if (!nrst_in)
			pull <= `PULL_RESET;
		else if (wr_in && hit_pull && !strap_load)
			pull <= wdata_in & `PULL_MASK;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus answers and status outputs.
	// Read data are zero outside the cycle after a read, so a stale value never lingers.
	always @*
	begin
		next_rdata = 8'h00;
		if (rd_in && hit_mode)
			next_rdata = {mode, 1'b0, vis, 1'b0, emulate_port_k, emulate_port_e};
		else if (rd_in && hit_pull)
			next_rdata = pull;
		else if (rd_in && hit_stat)
			next_rdata = {5'h00, pend, secure_in, mode_once_left};
	end

	assign own_addr   = (addr_in == `ADDR_BUS_CONFIG_SELECT) || (addr_in == `ADDR_PULL_RESISTOR_EN);
	assign next_echo  = (rd_in || wr_in) && !regs_mapped && own_addr;
	assign next_k_map = (mode != `M_PERIPHERAL) && (is_single || !is_expanded || !emulate_port_k);
	assign next_e_map = is_single || (!is_expanded && (mode != `M_PERIPHERAL)) || !emulate_port_e;

	always @(posedge clk_in)
	begin
		if (!nrst_in)
			rdata_out <= 8'h00;
		else
			rdata_out <= next_rdata;
	end

	// Echo marks an access that the external bus must carry instead of this block.
	always @(posedge clk_in)
	begin
		if (!nrst_in)
			echo_ext_out <= 1'b0;
		else
			echo_ext_out <= next_echo;
	end

	// Mode and visibility are shown one edge after the state, like every other output.
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			operating_mode_field_out <= 3'h0;
			internal_visibility_out  <= 1'b0;
			visible_cycle_out        <= 1'b0;
		end
		else
		begin
			operating_mode_field_out <= mode;
			internal_visibility_out  <= vis;
			visible_cycle_out        <= vis && int_access_in;
		end
	end

	// The map flags reset to mapped, which every single-chip strap needs at once.
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			port_k_mapped_out <= 1'b1;
			port_e_mapped_out <= 1'b1;
		end
		else
		begin
			port_k_mapped_out <= next_k_map;
			port_e_mapped_out <= next_e_map;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pull gating per port; port E bits 6 and 5 never follow the enable.
	pin_pull_gate u_pull_k
	(
		.clk_in      (clk_in),
		.nrst_in     (nrst_in),
		.port_en_in  (pull[`BIT_PULL_K]),
		.pin_mask_in (8'hFF),
		.dir_out_in  (port_k_dir_in),
		.pull_out    (pull_k_out)
	);

	pin_pull_gate u_pull_e
	(
		.clk_in      (clk_in),
		.nrst_in     (nrst_in),
		.port_en_in  (pull[`BIT_PULL_E]),
		.pin_mask_in (8'h9F),
		.dir_out_in  (port_e_dir_in),
		.pull_out    (pull_e_out)
	);

	pin_pull_gate u_pull_b
	(
		.clk_in      (clk_in),
		.nrst_in     (nrst_in),
		.port_en_in  (pull[`BIT_PULL_B]),
		.pin_mask_in (8'hFF),
		.dir_out_in  (port_b_dir_in),
		.pull_out    (pull_b_out)
	);

	pin_pull_gate u_pull_a
	(
		.clk_in      (clk_in),
		.nrst_in     (nrst_in),
		.port_en_in  (pull[`BIT_PULL_A]),
		.pin_mask_in (8'hFF),
		.dir_out_in  (port_a_dir_in),
		.pull_out    (pull_a_out)
	);
endmodule // bus_mode_and_pull_control
`default_nettype wire

// ===== verilog/bus_mode_defs.vh
// Offsets, field positions, reset values and mode codes of the bus mode and pull control block.
`ifndef BUS_MODE_DEFS_VH
`define BUS_MODE_DEFS_VH
`define ADDR_BUS_CONFIG_SELECT   4'hB
`define ADDR_PULL_RESISTOR_EN    4'hC
`define ADDR_STATUS              4'hD
`define MODE_HI                  7
`define MODE_LO                  5
`define BIT_VIS                  3
`define BIT_EMK                  1
`define BIT_EME                  0
`define BIT_PULL_K               7
`define BIT_PULL_E               4
`define BIT_PULL_B               1
`define BIT_PULL_A               0
`define PULL_RESET               8'h00
`define PULL_MASK                8'h93
`define M_SPECIAL_SINGLE         3'h0
`define M_EMUL_NARROW            3'h1
`define M_SPECIAL_TEST           3'h2
`define M_EMUL_WIDE              3'h3
`define M_NORMAL_SINGLE          3'h4
`define M_NORMAL_NARROW          3'h5
`define M_PERIPHERAL             3'h6
`define M_NORMAL_WIDE            3'h7
`endif

// ===== verilog/pin_pull_gate.v
// Per-pin pull gating: a port-wide enable acts only on pins set as inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_pull_gate
#(
	parameter WIDTH = 8
)
(
	input  wire             clk_in,
	input  wire             nrst_in,
	input  wire             port_en_in,
	input  wire [WIDTH-1:0] pin_mask_in,
	input  wire [WIDTH-1:0] dir_out_in,
	output reg  [WIDTH-1:0] pull_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_pin
			always @(posedge clk_in)
			begin
				if (!nrst_in)
					pull_out[i] <= 1'b0;
				else
					pull_out[i] <= port_en_in & pin_mask_in[i] & ~dir_out_in[i];
			end
		end
	endgenerate
endmodule // pin_pull_gate
`default_nettype wire
